// ===== rtl/dsp_ram_consts.svh
// Constants for the DSP memory update controller: offsets, fields, defaults, timing.
// Assumes inclusion by bare name from the design files; it holds definitions only.
`ifndef DSP_RAM_CONSTS_SVH
`define DSP_RAM_CONSTS_SVH
// ----------------------------------------------------------------------
// Memory geometry and APB register offsets
// ----------------------------------------------------------------------
`define PARAM_DEPTH            256
`define PROG_DEPTH             512
`define SAFE_COUNT             5
`define OFS_CTRL0              13'h1000
`define OFS_CTRL1              13'h1004
`define OFS_PROG_HI            13'h1008
`define OFS_BURST_ADDR         13'h100c
`define OFS_BURST_DATA         13'h1010
`define OFS_SAFE0              13'h1020
// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define CTRL0_SHUTDOWN_BIT     10
`define CTRL1_SAFE_DONE_BIT    0
`define CTRL1_HALTED_BIT       1
`define CTRL1_INITIATE_BIT     2
// ----------------------------------------------------------------------
// Parameter memory defaults (2.20 two's complement) and addresses
// ----------------------------------------------------------------------
`define PARAM_UNITY            22'h100000
`define PARAM_HALF             22'h080000
`define PARAM_ATTACK_DEF       22'h00025b
`define PARAM_HPF_DEF          22'h00019b
`define PARAM_SPREAD_FREQ_DEF  22'h01cd99
`define PARAM_DECAY_DEF        22'h011d20
`define HOLD_MAX               22'h000fff
`define BIQUAD_COEFS           8'h05
`define PA_BIQUAD_END          8'h6e
`define PA_MAIN_CURVE_HI       8'h8e
`define PA_MAIN_ATTACK         8'h8f
`define PA_MAIN_POST_GAIN      8'h90
`define PA_SUB_CURVE_LO        8'h91
`define PA_SUB_CURVE_HI        8'hb1
`define PA_SUB_ATTACK          8'hb2
`define PA_SUB_POST_GAIN       8'hb3
`define PA_HPF                 8'hb4
`define PA_SPREAD_FREQ         8'hba
`define PA_SUB_MIX_LEFT        8'hbd
`define PA_SUB_MIX_RIGHT       8'hbe
`define PA_HOLD_MAIN           8'hbf
`define PA_HOLD_SUB            8'hc0
`define PA_DECAY_MAIN          8'hc1
`define PA_DECAY_SUB           8'hc2
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCLK_MHZ               50
`define RAMP_TIME_US           15000
`define RAMP_STEPS             1024
`define RAMP_STEP_SIZE         22'h000400
`define SAFE_GAP_CYCLES        5
`endif

// ===== rtl/dsp_ram_pkg.sv
// Types shared by the DSP memory update controller.
// Assumes nothing of its surroundings.
package dsp_ram_pkg;
	typedef struct packed {
		logic        en;
		logic [7:0]  addr;
		logic [21:0] data;
	} param_wr_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [21:0] data;
	} safe_entry_t;

	typedef enum logic [3:0] {
		RAMP_RUN    = 4'b0001,
		RAMP_DOWN   = 4'b0010,
		CORE_HALTED = 4'b0100,
		RAMP_UP     = 4'b1000
	} ramp_state_t;
endpackage : dsp_ram_pkg

// ===== rtl/dsp_ram_update_control.sv
// Parameter and program memories of the audio DSP core with APB access, burst port,
// soft shutdown ramp and safeload transfers.
// Assumes an APB master on pclk and a core that flags param-free stretches on param_gap.
//
// Summary of operation
// [R1] Parameter memory 256x22, program memory 512x35 at 512-1023; read, write, burst.
// [R2] After boot, parameter words 110 to 142 hold unity.
// [R3] After boot, parameter words 145 to 177 hold unity.
// [R4] Hold-time counts default zero; values above 4095 are stored as 4095.
// [R5] Subwoofer mix gains at words 189 and 190 boot to one half.
// [R6] Direct memory access stays allowed while the core runs.
// [R7] Host should halt the core before large transfers and may use bursts.
// [R8] Burst port advances the memory address by one after each data word.
// [R9] Setting shutdown bit 10 ramps volume down over 10-20 ms, then halts.
// [R10] When halted, bit 1 of control register 1 reads as one.
// [R11] Host polls the halted flag or waits over 20 ms before free access.
// [R12] Clearing the shutdown bit restarts the core with a 10-20 ms ramp-up.
// [R13] Five safeload registers each hold a parameter address and data word.
// [R14] Writing the initiate bit of control register 1 arms a safeload.
// [R15] Armed transfer runs in a param-free stretch of five instruction cycles.
// [R16] Each staged word is written at the address held in its own register.
// [R17] Only safeload registers written since the last transfer are sent.
// [R18] The transfer completes within one audio frame of arming.
// [R19] Completion sets bit 0 of control register 1.
// [R20] The completion flag clears when the host reads it.
// [R21] Safeload can only target parameter memory addresses.
// [R22] Safeload word carries address byte, two zero bits, then 22-bit data.
// [R23] Parameter values are 2.20 two's complement fractions.
// [R24] Reset clears written markers, the pending request and both status flags.
`timescale 1ns/1ns
`include "dsp_ram_consts.svh"

module dsp_ram_update_control #(
	parameter int RAMP_CYCLES = `RAMP_TIME_US * `PCLK_MHZ
) (
	// Clock and reset.
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave.
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [12:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Core side.
	input  wire logic                        param_gap,
	input  wire logic [7:0]                  core_param_addr,
	output logic [21:0]                      core_param_data,
	input  wire logic [8:0]                  core_prog_addr,
	output logic [34:0]                      core_prog_data,
	output logic                             core_run,
	output logic [21:0]                      vol_gain,
	output dsp_ram_pkg::ramp_state_t         ramp_state
);
	import dsp_ram_pkg::*;

	localparam int STEP_RAW    = RAMP_CYCLES / `RAMP_STEPS;
	localparam int STEP_CYCLES = (STEP_RAW < 1) ? 1 : STEP_RAW;

	// ----------------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------------
	logic [21:0]  param_mem [`PARAM_DEPTH];
	logic [34:0]  prog_mem  [`PROG_DEPTH];
	safe_entry_t  safe_reg  [`SAFE_COUNT];
	logic [4:0]   safe_valid_reg;
	logic [10:0]  ctrl0_reg;
	logic [2:0]   prog_hi_reg;
	logic [9:0]   burst_addr_reg;
	logic [8:0]   boot_cnt_reg;
	logic         pending_reg;
	logic         safe_done_reg;
	logic         xfer_active_reg;
	logic [2:0]   slot_reg;
	logic [31:0]  prdata_reg;
	logic [21:0]  gain_reg;
	logic [15:0]  step_cnt_reg;
	ramp_state_t  state_reg;
	param_wr_t    param_wr;
	logic [31:0]  rd_value;

	// ----------------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------------
	logic [9:0]  idx;
	logic [9:0]  eff_idx;
	logic [12:0] safe_off;
	logic [2:0]  safe_sel;
	logic        hit_param, hit_prog, hit_ctrl0, hit_ctrl1, hit_prog_hi;
	logic        hit_baddr, hit_bdata, hit_safe, eff_param, eff_prog, mapped;
	logic        access, done, wr_done, boot_active, halted, shut_req;
	logic        step_tick, xfer_start, xfer_last, rd_clr, arm;

	assign idx         = paddr[11:2];
	assign safe_off    = paddr - `OFS_SAFE0;
	assign safe_sel    = safe_off[4:2];
	assign hit_ctrl0   = (paddr == `OFS_CTRL0);
	assign hit_ctrl1   = (paddr == `OFS_CTRL1);
	assign hit_prog_hi = (paddr == `OFS_PROG_HI);
	assign hit_baddr   = (paddr == `OFS_BURST_ADDR);
	assign hit_bdata   = (paddr == `OFS_BURST_DATA);
	assign hit_safe    = paddr[12] && (paddr >= `OFS_SAFE0) && (safe_off[12:2] < 11'd5);
	assign hit_param   = !paddr[12] && (idx[9:8] == 2'b00);
	assign hit_prog    = !paddr[12] && idx[9];
	assign eff_idx     = hit_bdata ? burst_addr_reg : idx;
	assign eff_param   = hit_param || (hit_bdata && burst_addr_reg[9:8] == 2'b00);
	assign eff_prog    = hit_prog || (hit_bdata && burst_addr_reg[9]);
	assign mapped      = eff_param || eff_prog || hit_ctrl0 || hit_ctrl1 || hit_prog_hi
	                     || hit_baddr || hit_safe;

	// Parameter writes wait while a safeload owns the write port, and all access waits boot.
	assign boot_active = !boot_cnt_reg[8];
	assign access      = psel && penable;
	assign pready      = !boot_active && !(xfer_active_reg && pwrite && eff_param);
	assign pslverr     = access && !mapped;
	assign done        = access && pready;
	assign wr_done     = done && pwrite && mapped;
	assign prdata      = prdata_reg;

	assign halted      = (state_reg == CORE_HALTED);
	assign shut_req    = ctrl0_reg[`CTRL0_SHUTDOWN_BIT];
	assign core_run    = !halted;
	assign vol_gain    = gain_reg;
	assign ramp_state  = state_reg;
	assign arm         = wr_done && hit_ctrl1 && pwdata[`CTRL1_INITIATE_BIT];
	assign xfer_start  = pending_reg && !xfer_active_reg && !boot_active
	                     && (param_gap || halted);
	assign xfer_last   = xfer_active_reg && (slot_reg == 3'(`SAFE_GAP_CYCLES - 1));
	assign rd_clr      = done && !pwrite && hit_ctrl1 && prdata_reg[`CTRL1_SAFE_DONE_BIT];

	// ----------------------------------------------------------------------
	// Parameter value functions
	// ----------------------------------------------------------------------
	function automatic logic [21:0] default_param(input logic [7:0] a);
		logic [21:0] v;
		v = 22'h000000;
		if (a < `PA_BIQUAD_END)
			v = ((a % `BIQUAD_COEFS) == 8'h00) ? `PARAM_UNITY : 22'h000000;
		else if (a <= `PA_MAIN_CURVE_HI)
			v = `PARAM_UNITY; // see [R2]
		else if (a >= `PA_SUB_CURVE_LO && a <= `PA_SUB_CURVE_HI)
			v = `PARAM_UNITY; // see [R3]
		else if (a == `PA_MAIN_ATTACK || a == `PA_SUB_ATTACK)
			v = `PARAM_ATTACK_DEF;
		else if (a == `PA_MAIN_POST_GAIN || a == `PA_SUB_POST_GAIN)
			v = `PARAM_UNITY;
		else if (a == `PA_HPF)
			v = `PARAM_HPF_DEF;
		else if (a == `PA_SPREAD_FREQ)
			v = `PARAM_SPREAD_FREQ_DEF;
		else if (a == `PA_SUB_MIX_LEFT || a == `PA_SUB_MIX_RIGHT)
			v = `PARAM_HALF; // see [R5]
		else if (a == `PA_DECAY_MAIN || a == `PA_DECAY_SUB)
			v = `PARAM_DECAY_DEF;
		return v;
	endfunction : default_param

	// Hold counts are unsigned sample counts; anything larger saturates.
	function automatic logic [21:0] clamp_param(input logic [7:0] a, input logic [21:0] d);
		logic hold;
		hold = (a == `PA_HOLD_MAIN) || (a == `PA_HOLD_SUB);
		return (hold && d > `HOLD_MAX) ? `HOLD_MAX : d; // see [R4]
	endfunction : clamp_param

	// ----------------------------------------------------------------------
	// Parameter write port: boot, then safeload, then APB
	// ----------------------------------------------------------------------
	always_comb
	begin
		param_wr = '0;
		if (boot_active)
		begin
			param_wr.en   = 1'b1;
			param_wr.addr = boot_cnt_reg[7:0];
			param_wr.data = default_param(boot_cnt_reg[7:0]);
		end
		else if (xfer_active_reg)
		begin
			param_wr.en   = safe_valid_reg[slot_reg]; // see [R17]
			param_wr.addr = safe_reg[slot_reg].addr; // see [R16] [R21]
			param_wr.data = clamp_param(safe_reg[slot_reg].addr, safe_reg[slot_reg].data);
		end
		else if (wr_done && eff_param)
		begin
			param_wr.en   = 1'b1; // see [R6]
			param_wr.addr = eff_idx[7:0];
			param_wr.data = clamp_param(eff_idx[7:0], pwdata[21:0]); // see [R23]
		end
	end

	always_ff @(posedge pclk)
	begin
		if (param_wr.en)
			param_mem[param_wr.addr] <= param_wr.data; // see [R1]
		if (wr_done && eff_prog)
			prog_mem[eff_idx[8:0]] <= {prog_hi_reg, pwdata};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_param_data <= 22'h000000;
			core_prog_data  <= 35'h000000000;
		end
		else
		begin
			core_param_data <= param_mem[core_param_addr];
			core_prog_data  <= prog_mem[core_prog_addr];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			boot_cnt_reg <= 9'h000;
		else if (boot_active)
			boot_cnt_reg <= boot_cnt_reg + 9'h001;
	end

	// ----------------------------------------------------------------------
	// APB read data
	// ----------------------------------------------------------------------
	always_comb
	begin
		rd_value = 32'h00000000;
		if (eff_param)
			rd_value = {10'h000, param_mem[eff_idx[7:0]]};
		else if (eff_prog)
			rd_value = prog_mem[eff_idx[8:0]][31:0];
		else if (hit_ctrl0)
			rd_value = {21'h000000, ctrl0_reg};
		else if (hit_ctrl1)
			rd_value = {29'h00000000, pending_reg, halted, safe_done_reg}; // see [R10]
		else if (hit_prog_hi)
			rd_value = {29'h00000000, prog_hi_reg};
		else if (hit_baddr)
			rd_value = {22'h000000, burst_addr_reg};
		else if (hit_safe)
			rd_value = {safe_reg[safe_sel].addr, 2'b00, safe_reg[safe_sel].data}; // see [R22]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_reg <= 32'h00000000;
		else if (psel && !pwrite)
			prdata_reg <= rd_value;
	end

	// ----------------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl0_reg <= 11'h000;
		else if (wr_done && hit_ctrl0)
			ctrl0_reg <= pwdata[10:0];
	end

	// High program bits stage a write and capture the top of the last program read.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prog_hi_reg <= 3'h0;
		else if (wr_done && hit_prog_hi)
			prog_hi_reg <= pwdata[2:0];
		else if (done && !pwrite && eff_prog)
			prog_hi_reg <= prog_mem[eff_idx[8:0]][34:32];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			burst_addr_reg <= 10'h000;
		else if (wr_done && hit_baddr)
			burst_addr_reg <= pwdata[9:0];
		else if (done && hit_bdata && mapped)
			burst_addr_reg <= burst_addr_reg + 10'h001; // see [R8]
	end

	always_ff @(posedge pclk)
	begin
		if (wr_done && hit_safe)
			safe_reg[safe_sel] <= {pwdata[31:24], pwdata[21:0]}; // see [R13] [R22]
	end

	// A new write to an entry in the cycle it is sent keeps it marked for the next transfer.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			safe_valid_reg <= 5'h00; // see [R24]
		else
			for (int i = 0; i < `SAFE_COUNT; i++)
			begin
				if (wr_done && hit_safe && safe_sel == 3'(i))
					safe_valid_reg[i] <= 1'b1;
				else if (xfer_active_reg && slot_reg == 3'(i))
					safe_valid_reg[i] <= 1'b0; // see [R17]
			end
	end

	// ----------------------------------------------------------------------
	// Safeload sequencing
	// ----------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pending_reg <= 1'b0; // see [R24]
		else if (arm)
			pending_reg <= 1'b1; // see [R14]
		else if (xfer_last)
			pending_reg <= 1'b0;
	end

	// The core raises param_gap where five param-free cycles follow; a halted core is always free.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			xfer_active_reg <= 1'b0;
			slot_reg        <= 3'h0;
		end
		else if (xfer_start)
		begin
			xfer_active_reg <= 1'b1; // see [R15] [R18]
			slot_reg        <= 3'h0;
		end
		else if (xfer_last)
			xfer_active_reg <= 1'b0;
		else if (xfer_active_reg)
			slot_reg <= slot_reg + 3'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			safe_done_reg <= 1'b0; // see [R24]
		else if (xfer_last)
			safe_done_reg <= 1'b1; // see [R19]
		else if (rd_clr)
			safe_done_reg <= 1'b0; // see [R20]
	end

	// ----------------------------------------------------------------------
	// Soft shutdown and restart ramp
	// ----------------------------------------------------------------------
	assign step_tick = (step_cnt_reg == 16'(STEP_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			step_cnt_reg <= 16'h0000;
		else if ((state_reg != RAMP_DOWN && state_reg != RAMP_UP) || step_tick)
			step_cnt_reg <= 16'h0000;
		else
			step_cnt_reg <= step_cnt_reg + 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= RAMP_RUN;
			gain_reg  <= `PARAM_UNITY;
		end
		else
			unique case (state_reg)
				RAMP_RUN:
					if (shut_req)
						state_reg <= RAMP_DOWN; // see [R9]
				RAMP_DOWN:
					if (!shut_req)
						state_reg <= RAMP_UP;
					else if (step_tick)
					begin
						gain_reg <= gain_reg - `RAMP_STEP_SIZE;
						if (gain_reg == `RAMP_STEP_SIZE)
							state_reg <= CORE_HALTED; // see [R9] [R10]
					end
				CORE_HALTED:
					if (!shut_req)
						state_reg <= RAMP_UP; // see [R12]
				RAMP_UP:
					if (shut_req)
						state_reg <= RAMP_DOWN;
					else if (step_tick)
					begin
						gain_reg <= gain_reg + `RAMP_STEP_SIZE;
						if (gain_reg == `PARAM_UNITY - `RAMP_STEP_SIZE)
							state_reg <= RAMP_RUN; // see [R12]
					end
			endcase
	end

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	halt_silent_a: assert property (halted |-> gain_reg == 22'h000000) // see [R9]
		else $error("core halted with nonzero gain");
	halt_entry_a: assert property (state_reg == RAMP_DOWN && shut_req && step_tick
		&& gain_reg == `RAMP_STEP_SIZE |=> halted && !core_run) // see [R10]
		else $error("ramp-down end did not halt the core");
	restart_ramp_a: assert property (halted && !shut_req |=> state_reg == RAMP_UP
		&& core_run && gain_reg == 22'h000000) // see [R12]
		else $error("clearing shutdown did not start ramp-up");
	burst_step_a: assert property (done && hit_bdata && mapped && !(pwrite && hit_baddr)
		|=> burst_addr_reg == $past(burst_addr_reg) + 10'h001) // see [R8]
		else $error("burst address did not advance");
	xfer_len_a: assert property ($rose(xfer_active_reg) |-> xfer_active_reg[*5]
		##1 !xfer_active_reg) // see [R15]
		else $error("safeload did not take five cycles");
	safe_target_a: assert property (xfer_active_reg && safe_valid_reg[slot_reg]
		|-> param_wr.en && param_wr.addr == safe_reg[slot_reg].addr) // see [R16]
		else $error("staged word not written at its address");
	skip_stale_a: assert property (xfer_active_reg && !safe_valid_reg[slot_reg]
		|-> !param_wr.en) // see [R17]
		else $error("unwritten safeload entry was sent");
	done_set_a: assert property (xfer_last |=> safe_done_reg && !pending_reg
		|| $past(arm)) // see [R19]
		else $error("completion flag not set after safeload");
	read_clear_a: assert property (rd_clr && !xfer_last |=> !safe_done_reg) // see [R20]
		else $error("completion flag not cleared by read");
	curve_boot_a: assert property (boot_active && boot_cnt_reg[7:0] >= `PA_BIQUAD_END
		&& boot_cnt_reg[7:0] <= `PA_MAIN_CURVE_HI |-> param_wr.data == `PARAM_UNITY) // see [R2]
		else $error("compressor curve default is not unity");
	hold_clamp_a: assert property (param_wr.en && (param_wr.addr == `PA_HOLD_MAIN
		|| param_wr.addr == `PA_HOLD_SUB) |-> param_wr.data <= `HOLD_MAX) // see [R4]
		else $error("hold count above maximum stored");

endmodule : dsp_ram_update_control

// ===== test/core_model.sv
// Behavioural DSP core: sweeps both read ports and flags param-free stretches.
// Assumes the bench drives gap_en and shares pclk and presetn with the controller.
`timescale 1ns/1ns

module core_model (
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Bench control.
	input  wire logic       gap_en,
	// Core memory side.
	output logic            param_gap,
	output logic [7:0]      core_param_addr,
	output logic [8:0]      core_prog_addr
);
	logic [3:0] cnt_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_reg <= 4'h0;
			param_gap <= 1'b0;
			core_param_addr <= 8'h00;
			core_prog_addr <= 9'h000;
		end
		else
		begin
			cnt_reg <= cnt_reg + 4'h1;
			// One stretch of five free cycles starts every sixteen cycles.
			param_gap <= gap_en && (cnt_reg == 4'hf);
			core_param_addr <= core_param_addr + 8'h01;
			core_prog_addr <= core_prog_addr + 9'h001;
		end
	end
endmodule : core_model

// ===== test/tb.sv
// Self-checking bench for the DSP memory update controller.
// Assumes the controller and the core model compile before it.
`timescale 1ns/1ns
`include "dsp_ram_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch at %0t: got %h want %h line %0d", $time, a, b, `__LINE__); end end

module tb;
	import dsp_ram_pkg::*;
	localparam int RC = 1024;
	logic pclk, presetn, psel, penable, pwrite, gap_en, param_gap, pready, pslverr, err, core_run;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata, rd, w;
	logic [7:0]  core_param_addr;
	logic [8:0]  core_prog_addr;
	logic [21:0] vol_gain, core_param_data, v, sd[5], hv[3];
	logic [34:0] core_prog_data;
	ramp_state_t ramp_state;
	int mismatches, n_checks, cyc, t0, n, k, sa[5];
	int pts[8] = '{110, 142, 145, 177, 189, 190, 191, 192};

	dsp_ram_update_control #(.RAMP_CYCLES(RC)) dsp_ram_update_control_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.param_gap(param_gap), .core_param_addr(core_param_addr),
		.core_param_data(core_param_data), .core_prog_addr(core_prog_addr),
		.core_prog_data(core_prog_data), .core_run(core_run),
		.vol_gain(vol_gain), .ramp_state(ramp_state));
	core_model core_model_i (.pclk(pclk), .presetn(presetn), .gap_en(gap_en),
		.param_gap(param_gap), .core_param_addr(core_param_addr),
		.core_prog_addr(core_prog_addr));

	function automatic logic [21:0] param_def(input int a);
		if ((a >= 110 && a <= 142) || (a >= 145 && a <= 177))
			return `PARAM_UNITY;
		if (a == 189 || a == 190)
			return `PARAM_HALF;
		return 22'h000000;
	endfunction : param_def

	function automatic logic [21:0] hold_sat(input logic [21:0] x);
		return (x > `HOLD_MAX) ? `HOLD_MAX : x;
	endfunction : hold_sat

	task automatic apb(input logic wr, input int a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= 13'(a);
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wait_done;
		n = 0;
		do
		begin
			apb(0, `OFS_CTRL1, 0);
			n++;
		end
		while (rd[0] !== 1'b1 && n < 40);
	endtask : wait_done

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude

	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			mismatches++;
			conclude;
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite, gap_en, paddr, pwdata} = '0;
		void'($urandom(32'h27bef3c0));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// ----------------------------------------------------------------
		// Boot defaults, hold saturation, direct and program access
		// ----------------------------------------------------------------
		foreach (pts[i])
		begin
			apb(0, 4 * pts[i], 0);
			`CHK(rd, {10'h000, param_def(pts[i])})
		end
		while (core_param_addr !== 8'd189)
			@(posedge pclk);
		@(posedge pclk);
		`CHK(core_param_data, `PARAM_HALF)
		hv = '{22'($urandom), 22'h000fff, 22'h001000};
		foreach (hv[i])
		begin
			apb(1, 764, {10'h000, hv[i]});
			apb(0, 764, 0);
			`CHK(rd, {10'h000, hold_sat(hv[i])})
		end
		v = 22'($urandom);
		k = $urandom % 100;
		apb(1, 4 * k, {10'h000, v});
		apb(0, 4 * k, 0);
		`CHK(rd, {10'h000, v})
		w = $urandom;
		k = $urandom % 512;
		apb(1, `OFS_PROG_HI, {29'h0, v[2:0]});
		apb(1, 4 * (512 + k), w);
		apb(1, `OFS_PROG_HI, 0);
		apb(0, 4 * (512 + k), 0);
		`CHK(rd, w)
		apb(0, `OFS_PROG_HI, 0);
		`CHK(rd[2:0], v[2:0])
		while (core_prog_addr !== 9'(k))
			@(posedge pclk);
		@(posedge pclk);
		`CHK(core_prog_data, {v[2:0], w})
		apb(0, 13'h400, 0);
		`CHK({err, rd}, 33'h100000000)
		// ----------------------------------------------------------------
		// Burst into parameter memory
		// ----------------------------------------------------------------
		apb(1, `OFS_BURST_ADDR, 20);
		for (int i = 0; i < 3; i++)
		begin
			sd[i] = 22'($urandom);
			apb(1, `OFS_BURST_DATA, {10'h000, sd[i]});
		end
		for (int i = 0; i < 3; i++)
		begin
			apb(0, 4 * (20 + i), 0);
			`CHK(rd[21:0], sd[i])
		end
		// ----------------------------------------------------------------
		// Safeload: all entries, then only 0 and 2..4 with entry 1 stale
		// ----------------------------------------------------------------
		gap_en <= 1'b1;
		for (int r = 0; r < 2; r++)
		begin
			for (int e = 0; e < 5; e++)
				if (r == 0 || e != 1)
				begin
					sa[e] = e * 20 + 1 + $urandom % 15;
					sd[e] = 22'($urandom);
					apb(1, `OFS_SAFE0 + 4 * e, {8'(sa[e]), 2'b00, sd[e]});
				end
			if (r == 1)
			begin
				sd[1] = ~sd[1];
				apb(1, 4 * sa[1], {10'h000, sd[1]});
			end
			apb(1, `OFS_CTRL1, 32'h4);
			wait_done;
			`CHK(rd[0], 1'b1)
			apb(0, `OFS_CTRL1, 0);
			`CHK(rd[0], 1'b0)
			for (int e = 0; e < 5; e++)
			begin
				apb(0, 4 * sa[e], 0);
				`CHK(rd[21:0], sd[e])
			end
		end
		// ----------------------------------------------------------------
		// Reset while a request is pending
		// ----------------------------------------------------------------
		gap_en <= 1'b0;
		apb(1, `OFS_SAFE0, 32'h05000000);
		apb(1, `OFS_CTRL1, 32'h4);
		apb(0, `OFS_CTRL1, 0);
		`CHK(rd[2], 1'b1)
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(0, `OFS_CTRL1, 0);
		`CHK(rd[2:0], 3'b000)
		// The entry staged before reset must not be sent by the next transfer.
		gap_en <= 1'b1;
		apb(1, `OFS_CTRL1, 32'h4);
		wait_done;
		`CHK(rd[0], 1'b1)
		apb(0, 4 * 5, 0);
		`CHK(rd[21:0], `PARAM_UNITY)
		// ----------------------------------------------------------------
		// Soft shutdown, burst to program memory while halted, restart
		// ----------------------------------------------------------------
		apb(1, `OFS_CTRL0, 32'h400);
		t0 = cyc;
		while (ramp_state !== CORE_HALTED && cyc - t0 < 3 * RC)
			@(posedge pclk);
		`CHK(cyc - t0 >= RC * 2 / 3 && cyc - t0 <= RC * 4 / 3, 1'b1)
		`CHK({core_run, vol_gain}, 23'h0)
		apb(0, `OFS_CTRL1, 0);
		`CHK(rd[1], 1'b1)
		apb(1, `OFS_BURST_ADDR, 600);
		apb(1, `OFS_BURST_DATA, w);
		apb(0, 4 * 600, 0);
		`CHK(rd, w)
		apb(1, `OFS_CTRL0, 0);
		t0 = cyc;
		while (ramp_state !== RAMP_RUN && cyc - t0 < 3 * RC)
			@(posedge pclk);
		`CHK(cyc - t0 >= RC * 2 / 3 && cyc - t0 <= RC * 4 / 3, 1'b1)
		`CHK({core_run, vol_gain}, {1'b1, `PARAM_UNITY})
		conclude;
	end
endmodule : tb
